// ===== core/csl_pkg.sv
/*
 Constants, field layout, enumerations and carrier types of the charger
 supervisory logic. Assumes a 40 MHz system clock.
*/
package csl_pkg;
  // ****************
  // Timing
  // ****************
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = TICK_US * 1000 / CLK_PERIOD_NS;
  localparam int OVP_RISE_US = 100;
  localparam int OVP_RISE_CYC = (OVP_RISE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OVP_FALL_US = 1000;
  localparam int OVP_FALL_CYC = (OVP_FALL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OPT_RUN_MS = 2000;
  localparam int OPT_STEP_MS = 50;
  localparam int WD_S1 = 5;
  localparam int WD_S2 = 88;
  localparam int WD_S3 = 175;
  // ****************
  // Serial port and register offsets
  // ****************
  localparam logic [6:0] DEV_ADDR = 7'h6b;
  localparam logic [7:0] OFS_CHG_CUR = 8'h02;
  localparam logic [7:0] OFS_CHG_VOLT = 8'h04;
  localparam logic [7:0] OFS_WDOG = 8'h06;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_HOST_LIM = 8'h0a;
  localparam logic [7:0] OFS_DYN_LIM = 8'h0c;
  localparam logic [7:0] OFS_PEAK = 8'h0e;
  localparam logic [7:0] OFS_L2PCT = 8'h10;
  localparam logic [7:0] OFS_VIN_SET = 8'h12;
  localparam logic [7:0] OFS_HOT_EN = 8'h14;
  localparam logic [7:0] OFS_HOT_STAT = 8'h16;
  localparam logic [7:0] OFS_LP_A = 8'h30;
  localparam logic [7:0] OFS_LP_B = 8'h34;
  // ****************
  // Fields and reset values
  // ****************
  localparam int CTRL_OPT_EN = 0;
  localparam int CTRL_OPT_DONE = 1;
  localparam int CTRL_LPWR = 2;
  localparam int CTRL_LP_HOT = 3;
  localparam int CTRL_PK_OVS = 4;
  localparam int CTRL_EXT = 5;
  localparam int CTRL_CLR = 6;
  localparam int ST_VIN = 4;
  localparam int ST_EXIT = 5;
  localparam logic [7:0] CTRL_RST = 8'h40;
  localparam logic [1:0] WD_RST = 2'h3;
  localparam logic [7:0] PEAK_RST = 8'h3f;
  localparam logic [7:0] L2PCT_RST = 8'h96;
  localparam logic [7:0] HOST_LIM_RST = 8'h28;
  localparam logic [7:0] HOT_EN_RST = 8'h1f;
  localparam int LIM_LSB_MA = 50;
  localparam int OPT_MIN_MA = 500;
  localparam logic [7:0] OPT_MIN_CODE = 8'(OPT_MIN_MA / LIM_LSB_MA);
  localparam int CUR_LSB_MA = 64;
  localparam int WD_CUR_MA = 256;
  localparam logic [7:0] WD_CUR_CODE = 8'(WD_CUR_MA / CUR_LSB_MA);
  localparam logic [7:0] PCT_FULL = 8'h64;
  localparam logic [7:0] PCT_HOT = 8'h6e;
  localparam logic [7:0] PCT_LOW = 8'h53;
  localparam logic [7:0] PCT_MID = 8'h5b;
  // ****************
  // Types
  // ****************
  typedef struct packed {
    logic surge;
    logic discharge;
    logic over_dyn;
    logic critical;
    logic nominal;
    logic dis1;
    logic dis2;
    logic vin_low;
    logic assist;
    logic cmp_high;
    logic ov_above_rise;
    logic ov_below_fall;
    logic droop;
  } csl_sense_type;
  typedef enum logic [4:0] {
    I2C_IDLE = 5'b00001, I2C_RX = 5'b00010, I2C_ACK = 5'b00100,
    I2C_TX = 5'b01000, I2C_TXACK = 5'b10000
  } csl_i2c_type;
  typedef enum logic [2:0] {
    PK_IDLE = 3'b001, PK_OVLD = 3'b010, PK_REST = 3'b100
  } csl_peak_type;
  typedef enum logic [2:0] {
    OPT_IDLE = 3'b001, OPT_RUN = 3'b010, OPT_DONE = 3'b100
  } csl_opt_type;
endpackage

// ===== core/csl_top.sv
/*
 Supervisory logic of a buck-boost charge controller: serial register
 slave, current optimizer, peak power timing, throttle events, watchdog
 and input overvoltage. Assumes analog comparators outside deliver levels.
*/
`timescale 1ns/1ps
module csl_top #(
  parameter int TICK_CYC = csl_pkg::TICK_CYC,
  parameter int OVP_FALL_CYC = csl_pkg::OVP_FALL_CYC
) (
  // Clock and reset
  input logic clock_i,
  input logic sys_rst_i,
  // Serial register port
  input logic scl_i,
  input logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Analog comparator levels
  input csl_pkg::csl_sense_type sense_i,
  // Regulation settings
  output logic [7:0] charge_current_o,
  output logic [7:0] charge_voltage_o,
  output logic [10:0] applied_limit_o,
  output logic [10:0] critical_threshold_o,
  output logic [10:0] nominal_threshold_o,
  output logic [10:0] vin_threshold_o,
  // Power path and throttle
  output logic charge_enable_o,
  output logic converter_enable_o,
  output logic charger_ok_o,
  output logic throttle_output_n_o,
  output logic throttle_oe_o
);
  function automatic logic [10:0] pct(input logic [7:0] v, input logic [7:0] p);
    logic [15:0] m;
    m = 16'(v) * 16'(p);
    return 11'(m / 16'(csl_pkg::PCT_FULL));
  endfunction
  function automatic logic [17:0] wd_ms(input logic [1:0] f);
    case (f)
      2'h1: wd_ms = 18'(csl_pkg::WD_S1 * 1000);
      2'h2: wd_ms = 18'(csl_pkg::WD_S2 * 1000);
      2'h3: wd_ms = 18'(csl_pkg::WD_S3 * 1000);
      default: wd_ms = 18'h0;
    endcase
  endfunction
  function automatic logic [5:0] code_ms(input logic [1:0] f, input logic [5:0] s);
    case (f)
      2'h0: code_ms = s;
      2'h1: code_ms = 6'(s * 2);
      2'h2: code_ms = 6'(s * 4);
      default: code_ms = 6'(s * 8);
    endcase
  endfunction

  // ****************
  // Input synchronisers
  // ****************
  csl_pkg::csl_sense_type sense_m_r, sense_r, sense_q_r;
  logic scl_m_r, scl_r, scl_q_r, sda_m_r, sda_r, sda_q_r;
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sense_m_r <= '0;
      sense_r <= '0;
      sense_q_r <= '0;
      {scl_m_r, scl_r, scl_q_r} <= 3'h7;
      {sda_m_r, sda_r, sda_q_r} <= 3'h7;
    end else begin
      sense_m_r <= sense_i;
      sense_r <= sense_m_r;
      sense_q_r <= sense_r;
      {scl_m_r, scl_r, scl_q_r} <= {scl_i, scl_m_r, scl_r};
      {sda_m_r, sda_r, sda_q_r} <= {sda_i, sda_m_r, sda_r};
    end
  end
  logic i2c_start, i2c_stop, scl_rise, scl_fall;
  assign i2c_start = scl_r & scl_q_r & sda_q_r & ~sda_r;
  assign i2c_stop = scl_r & scl_q_r & ~sda_q_r & sda_r;
  assign scl_rise = scl_r & ~scl_q_r;
  assign scl_fall = ~scl_r & scl_q_r;

  // ****************
  // Time base
  // ****************
  logic [15:0] pre_r;
  logic tick_r;
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pre_r <= 16'h0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (pre_r == 16'(TICK_CYC - 1));
      pre_r <= (pre_r == 16'(TICK_CYC - 1)) ? 16'h0 : pre_r + 16'h1;
    end
  end

  // ****************
  // Serial register slave
  // ****************
  csl_pkg::csl_i2c_type i2c_r;
  logic [7:0] sh_r, tx_r, ptr_r, wr_addr_r, wr_data_r, rd_addr_r, rd_mux;
  logic [3:0] cnt_r;
  logic [1:0] idx_r;
  logic rw_r, nack_r, wr_stb_r, rd_stb_r, sda_oe_r;
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      i2c_r <= csl_pkg::I2C_IDLE;
      {sh_r, tx_r, ptr_r, wr_addr_r, wr_data_r, rd_addr_r} <= '0;
      cnt_r <= 4'h0;
      idx_r <= 2'h0;
      {rw_r, nack_r, wr_stb_r, rd_stb_r, sda_oe_r} <= 5'h0;
    end else begin
      wr_stb_r <= 1'b0;
      rd_stb_r <= 1'b0;
      if (i2c_start) begin
        i2c_r <= csl_pkg::I2C_RX;
        cnt_r <= 4'h0;
        idx_r <= 2'h0;
        sda_oe_r <= 1'b0;
      end else if (i2c_stop) begin
        i2c_r <= csl_pkg::I2C_IDLE;
        sda_oe_r <= 1'b0;
      end else begin
        case (i2c_r)
          csl_pkg::I2C_RX: begin
            if (scl_rise) begin
              sh_r <= {sh_r[6:0], sda_r};
              cnt_r <= cnt_r + 4'h1;
            end else if (scl_fall && cnt_r == 4'h8) begin
              cnt_r <= 4'h0;
              if (idx_r == 2'h0 && sh_r[7:1] != csl_pkg::DEV_ADDR) begin
                i2c_r <= csl_pkg::I2C_IDLE;
              end else begin
                sda_oe_r <= 1'b1;
                i2c_r <= csl_pkg::I2C_ACK;
                if (idx_r == 2'h0) begin
                  rw_r <= sh_r[0];
                end else if (idx_r == 2'h1) begin
                  ptr_r <= sh_r;
                end else begin
                  wr_stb_r <= 1'b1;
                  wr_addr_r <= ptr_r;
                  wr_data_r <= sh_r;
                  ptr_r <= ptr_r + 8'h1;
                end
              end
            end
          end
          csl_pkg::I2C_ACK: begin
            if (scl_fall) begin
              if (idx_r != 2'h2) begin
                idx_r <= idx_r + 2'h1;
              end
              if (idx_r == 2'h0 && rw_r) begin
                tx_r <= rd_mux;
                rd_stb_r <= 1'b1;
                rd_addr_r <= ptr_r;
                ptr_r <= ptr_r + 8'h1;
                sda_oe_r <= ~rd_mux[7];
                i2c_r <= csl_pkg::I2C_TX;
              end else begin
                sda_oe_r <= 1'b0;
                i2c_r <= csl_pkg::I2C_RX;
              end
            end
          end
          csl_pkg::I2C_TX: begin
            if (scl_fall) begin
              if (cnt_r == 4'h7) begin
                sda_oe_r <= 1'b0;
                cnt_r <= 4'h0;
                i2c_r <= csl_pkg::I2C_TXACK;
              end else begin
                tx_r <= {tx_r[6:0], 1'b0};
                sda_oe_r <= ~tx_r[6];
                cnt_r <= cnt_r + 4'h1;
              end
            end
          end
          csl_pkg::I2C_TXACK: begin
            if (scl_rise) begin
              nack_r <= sda_r;
            end else if (scl_fall) begin
              if (nack_r) begin
                i2c_r <= csl_pkg::I2C_IDLE;
              end else begin
                tx_r <= rd_mux;
                rd_stb_r <= 1'b1;
                rd_addr_r <= ptr_r;
                ptr_r <= ptr_r + 8'h1;
                sda_oe_r <= ~rd_mux[7];
                i2c_r <= csl_pkg::I2C_TX;
              end
            end
          end
          default: begin
            sda_oe_r <= 1'b0;
          end
        endcase
      end
    end
  end
  function automatic logic wr_at(input logic [7:0] a, input logic s, input logic [7:0] w);
    return s && (a == w);
  endfunction

  // ****************
  // Configuration registers
  // ****************
  logic [7:0] ctrl_r, host_lim_r, peak_r, l2pct_r, vin_set_r, hot_en_r, lp_a_r, lp_b_r;
  logic [7:0] chg_volt_r, chg_cur_r, dyn_lim_r, stat_r;
  logic [1:0] wd_fld_r;
  logic opt_done_r;
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_r <= csl_pkg::CTRL_RST;
      host_lim_r <= csl_pkg::HOST_LIM_RST;
      peak_r <= csl_pkg::PEAK_RST;
      l2pct_r <= csl_pkg::L2PCT_RST;
      hot_en_r <= csl_pkg::HOT_EN_RST;
      wd_fld_r <= csl_pkg::WD_RST;
      {vin_set_r, lp_a_r, lp_b_r, chg_volt_r} <= '0;
    end else if (wr_stb_r) begin
      case (wr_addr_r)
        csl_pkg::OFS_CTRL: ctrl_r <= wr_data_r;
        csl_pkg::OFS_HOST_LIM: host_lim_r <= wr_data_r;
        csl_pkg::OFS_PEAK: peak_r <= wr_data_r;
        csl_pkg::OFS_L2PCT: l2pct_r <= wr_data_r;
        csl_pkg::OFS_VIN_SET: vin_set_r <= wr_data_r;
        csl_pkg::OFS_HOT_EN: hot_en_r <= wr_data_r;
        csl_pkg::OFS_WDOG: wd_fld_r <= wr_data_r[1:0];
        csl_pkg::OFS_CHG_VOLT: chg_volt_r <= wr_data_r;
        csl_pkg::OFS_LP_A: lp_a_r <= wr_data_r;
        csl_pkg::OFS_LP_B: lp_b_r <= wr_data_r;
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end
  always_comb begin
    case (ptr_r)
      csl_pkg::OFS_CHG_CUR: rd_mux = chg_cur_r;
      csl_pkg::OFS_CHG_VOLT: rd_mux = chg_volt_r;
      csl_pkg::OFS_WDOG: rd_mux = {6'h0, wd_fld_r};
      csl_pkg::OFS_CTRL: rd_mux = {ctrl_r[7:2], opt_done_r, ctrl_r[0]};
      csl_pkg::OFS_HOST_LIM: rd_mux = host_lim_r;
      csl_pkg::OFS_DYN_LIM: rd_mux = dyn_lim_r;
      csl_pkg::OFS_PEAK: rd_mux = peak_r;
      csl_pkg::OFS_L2PCT: rd_mux = l2pct_r;
      csl_pkg::OFS_VIN_SET: rd_mux = vin_set_r;
      csl_pkg::OFS_HOT_EN: rd_mux = hot_en_r;
      csl_pkg::OFS_HOT_STAT: rd_mux = stat_r;
      csl_pkg::OFS_LP_A: rd_mux = lp_a_r;
      csl_pkg::OFS_LP_B: rd_mux = lp_b_r;
      default: rd_mux = 8'h0;
    endcase
  end

  // ****************
  // Input current optimizer
  // ****************
  csl_pkg::csl_opt_type opt_r;
  logic [10:0] opt_ms_r;
  logic [5:0] opt_step_r;
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      opt_r <= csl_pkg::OPT_IDLE;
      dyn_lim_r <= csl_pkg::HOST_LIM_RST;
      opt_ms_r <= 11'h0;
      opt_step_r <= 6'h0;
      opt_done_r <= 1'b0;
    end else if (!ctrl_r[csl_pkg::CTRL_OPT_EN]) begin
      opt_r <= csl_pkg::OPT_IDLE;
      dyn_lim_r <= host_lim_r;
      opt_done_r <= 1'b0;
    end else begin
      case (opt_r)
        csl_pkg::OPT_IDLE: begin
          dyn_lim_r <= host_lim_r;
          opt_ms_r <= 11'h0;
          opt_step_r <= 6'h0;
          if (host_lim_r > csl_pkg::OPT_MIN_CODE) begin
            opt_r <= csl_pkg::OPT_RUN;
          end
        end
        csl_pkg::OPT_RUN: begin
          if (tick_r) begin
            opt_ms_r <= opt_ms_r + 11'h1;
            opt_step_r <= (opt_step_r == 6'(csl_pkg::OPT_STEP_MS - 1)) ? 6'h0 : opt_step_r + 6'h1;
            if (opt_step_r == 6'(csl_pkg::OPT_STEP_MS - 1) && sense_r.droop &&
                dyn_lim_r > csl_pkg::OPT_MIN_CODE) begin
              dyn_lim_r <= dyn_lim_r - 8'h1;
            end
            if (opt_ms_r == 11'(csl_pkg::OPT_RUN_MS - 1)) begin
              opt_r <= csl_pkg::OPT_DONE;
              opt_done_r <= 1'b1;
            end
          end
        end
        csl_pkg::OPT_DONE: opt_done_r <= 1'b1;
        default: opt_r <= csl_pkg::OPT_IDLE;
      endcase
    end
  end

  // ****************
  // Peak power timing
  // ****************
  csl_pkg::csl_peak_type pk_r;
  logic [5:0] pk_ms_r;
  logic load_high;
  assign load_high = (sense_r.surge & sense_r.discharge) |
                     (ctrl_r[csl_pkg::CTRL_PK_OVS] & sense_r.over_dyn);
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pk_r <= csl_pkg::PK_IDLE;
      pk_ms_r <= 6'h0;
    end else begin
      if (tick_r) begin
        pk_ms_r <= pk_ms_r + 6'h1;
      end
      case (pk_r)
        csl_pkg::PK_IDLE: begin
          pk_ms_r <= 6'h0;
          if (load_high) begin
            pk_r <= csl_pkg::PK_OVLD;
          end
        end
        csl_pkg::PK_OVLD: begin
          if (pk_ms_r >= code_ms(peak_r[1:0], 6'h1)) begin
            pk_r <= csl_pkg::PK_REST;
          end
        end
        csl_pkg::PK_REST: begin
          if (pk_ms_r >= code_ms(peak_r[3:2], 6'h5)) begin
            pk_ms_r <= 6'h0;
            pk_r <= load_high ? csl_pkg::PK_OVLD : csl_pkg::PK_IDLE;
          end
        end
        default: pk_r <= csl_pkg::PK_IDLE;
      endcase
    end
  end

  // ****************
  // Throttle events
  // ****************
  logic [6:0] act, act_q_r;
  logic [5:0] pulse_r;
  logic hold_r, ext_r, trig, clr_wr;
  assign act[4:0] = {sense_r.vin_low, sense_r.dis2, sense_r.dis1, sense_r.nominal,
                     sense_r.critical} & hot_en_r[4:0];
  assign act[5] = sense_q_r.assist & ~sense_r.assist;
  assign act[6] = ctrl_r[csl_pkg::CTRL_LPWR] & ctrl_r[csl_pkg::CTRL_LP_HOT] &
                  sense_r.cmp_high;
  assign trig = |(act & ~act_q_r);
  assign clr_wr = wr_at(wr_addr_r, wr_stb_r, csl_pkg::OFS_CTRL) &
                  ~wr_data_r[csl_pkg::CTRL_CLR];
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      act_q_r <= 7'h0;
      stat_r <= 8'h0;
    end else begin
      act_q_r <= act;
      for (int i = 0; i < 7; i++) begin
        if (act[i]) begin
          stat_r[i] <= 1'b1;
        end else if (i == csl_pkg::ST_VIN || i == csl_pkg::ST_EXIT) begin
          if (wr_at(wr_addr_r, wr_stb_r, csl_pkg::OFS_HOT_STAT) && !wr_data_r[i]) begin
            stat_r[i] <= 1'b0;
          end
        end else if (wr_at(rd_addr_r, rd_stb_r, csl_pkg::OFS_HOT_STAT)) begin
          stat_r[i] <= 1'b0;
        end
      end
    end
  end
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pulse_r <= 6'h0;
      hold_r <= 1'b0;
      ext_r <= 1'b0;
    end else begin
      if (trig) begin
        pulse_r <= code_ms(peak_r[5:4], 6'h1) + 6'h1;
        hold_r <= 1'b1;
      end else begin
        if (tick_r && pulse_r != 6'h0) begin
          pulse_r <= pulse_r - 6'h1;
        end
        if (pulse_r == 6'h0 && act == 7'h0) begin
          hold_r <= 1'b0;
        end
      end
      if (trig && ctrl_r[csl_pkg::CTRL_EXT]) begin
        ext_r <= 1'b1;
      end else if (clr_wr) begin
        ext_r <= 1'b0;
      end
    end
  end

  // ****************
  // Watchdog
  // ****************
  logic [17:0] wd_ms_r;
  logic wd_exp_r, wd_kick;
  assign wd_kick = wr_at(wr_addr_r, wr_stb_r, csl_pkg::OFS_CHG_CUR) |
                   wr_at(wr_addr_r, wr_stb_r, csl_pkg::OFS_CHG_VOLT) |
                   wr_at(wr_addr_r, wr_stb_r, csl_pkg::OFS_WDOG);
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wd_ms_r <= 18'h0;
      wd_exp_r <= 1'b0;
      chg_cur_r <= 8'h0;
    end else begin
      if (wr_at(wr_addr_r, wr_stb_r, csl_pkg::OFS_CHG_CUR)) begin
        chg_cur_r <= wr_data_r;
      end
      if (wd_kick) begin
        wd_ms_r <= 18'h0;
        wd_exp_r <= 1'b0;
      end else if (tick_r && !wd_exp_r && wd_fld_r != 2'h0) begin
        wd_ms_r <= wd_ms_r + 18'h1;
        if (wd_ms_r == wd_ms(wd_fld_r) - 18'h1) begin
          wd_exp_r <= 1'b1;
          chg_cur_r <= csl_pkg::WD_CUR_CODE;
        end
      end
    end
  end

  // ****************
  // Input overvoltage
  // ****************
  logic [11:0] ov_rise_r;
  logic [15:0] ov_fall_r;
  logic ov_r;
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ov_rise_r <= 12'h0;
      ov_fall_r <= 16'h0;
      ov_r <= 1'b0;
    end else if (!ov_r) begin
      ov_fall_r <= 16'h0;
      ov_rise_r <= sense_r.ov_above_rise ? ov_rise_r + 12'h1 : 12'h0;
      if (sense_r.ov_above_rise && ov_rise_r == 12'(csl_pkg::OVP_RISE_CYC - 1)) begin
        ov_r <= 1'b1;
      end
    end else begin
      ov_rise_r <= 12'h0;
      ov_fall_r <= sense_r.ov_below_fall ? ov_fall_r + 16'h1 : 16'h0;
      if (sense_r.ov_below_fall && ov_fall_r == 16'(OVP_FALL_CYC - 1)) begin
        ov_r <= 1'b0;
      end
    end
  end

  // ****************
  // Output registers
  // ****************
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {sda_o, sda_oe_o, charge_current_o, charge_voltage_o} <= '0;
      {applied_limit_o, critical_threshold_o, nominal_threshold_o} <= '0;
      vin_threshold_o <= 11'h0;
      {charge_enable_o, converter_enable_o, throttle_oe_o} <= 3'h0;
      charger_ok_o <= 1'b0;
      throttle_output_n_o <= 1'b1;
    end else begin
      sda_o <= 1'b0;
      sda_oe_o <= sda_oe_r;
      charge_current_o <= chg_cur_r;
      charge_voltage_o <= chg_volt_r;
      applied_limit_o <= (pk_r == csl_pkg::PK_OVLD) ? pct(dyn_lim_r, l2pct_r) :
                         {3'h0, dyn_lim_r};
      critical_threshold_o <= 11'(({21'h0, pct(dyn_lim_r, l2pct_r)} *
                              32'(csl_pkg::PCT_HOT)) / 32'(csl_pkg::PCT_FULL));
      nominal_threshold_o <= pct(dyn_lim_r, csl_pkg::PCT_HOT);
      if (!hot_en_r[6]) begin
        vin_threshold_o <= pct(vin_set_r, csl_pkg::PCT_FULL);
      end else begin
        vin_threshold_o <= pct(vin_set_r, hot_en_r[5] ? csl_pkg::PCT_MID : csl_pkg::PCT_LOW);
      end
      charge_enable_o <= (pk_r != csl_pkg::PK_REST) & ~ov_r;
      converter_enable_o <= ~ov_r;
      charger_ok_o <= ~ov_r;
      throttle_output_n_o <= ~(hold_r | ext_r | act[6] | stat_r[csl_pkg::ST_VIN] |
                             stat_r[csl_pkg::ST_EXIT]);
      throttle_oe_o <= hold_r | ext_r | act[6] | stat_r[csl_pkg::ST_VIN] |
                       stat_r[csl_pkg::ST_EXIT];
    end
  end
endmodule

// ===== verif/charger_supervisory_logic_tb.sv
/* Bench for csl_top with host model. Assumes shortened tick parameters. */
`timescale 1ns/1ps
module charger_supervisory_logic_tb;
  localparam int TK = 10;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  csl_pkg::csl_sense_type sense_i = '0;
  logic scl, sda, sda_oe, ack, chg_en, conv_en, ok, thr_n, thr_oe;
  logic [7:0] cur;
  logic [10:0] lim, crit, nom, vth;
  int n_mismatch = 0;
  int compares = 0;
  int n;
  always #12.5 clock_i = ~clock_i;
  csl_top #(.TICK_CYC(TK), .OVP_FALL_CYC(400)) dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .sense_i(sense_i),
    .charge_current_o(cur), .charge_voltage_o(), .applied_limit_o(lim),
    .critical_threshold_o(crit), .nominal_threshold_o(nom), .vin_threshold_o(vth),
    .charge_enable_o(chg_en),
    .converter_enable_o(conv_en), .charger_ok_o(ok), .throttle_output_n_o(thr_n),
    .throttle_oe_o(thr_oe));
  csl_host_model host (.clock_i(clock_i), .dev_pull_i(sda_oe), .scl_o(scl), .sda_o(sda),
    .ack_o(ack));
  task automatic chk(input string nm, input logic [10:0] seen, input logic [10:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wait_lvl(ref logic s, input logic lvl, input int lim);
    n = 0;
    while (s !== lvl && n < lim) begin
      @(negedge clock_i);
      n++;
    end
    if (s !== lvl) begin
      n_mismatch++;
      conclude();
    end
  endtask
  task automatic t_pulse;
    sense_i.critical = 1'b1;
    repeat (4) @(negedge clock_i);
    sense_i.critical = 1'b0;
    wait_lvl(thr_n, 1'b0, 12);
    wait_lvl(thr_n, 1'b1, 12 * TK);
    chk("width", {10'h000, n >= 8 * TK && n <= 9 * TK + 4}, 11'h001);
    chk("pin_oe", {10'h000, thr_oe}, 11'h000);
  endtask
  task automatic t_stretch;
    sense_i.nominal = 1'b1;
    wait_lvl(thr_n, 1'b0, 12);
    repeat (15 * TK) @(negedge clock_i);
    chk("stretch", {10'h000, thr_n}, 11'h000);
    sense_i.nominal = 1'b0;
    wait_lvl(thr_n, 1'b1, 12);
  endtask
  task automatic t_ov;
    sense_i.ov_above_rise = 1'b1;
    repeat (3900) @(negedge clock_i);
    chk("ok_early", {10'h000, ok}, 11'h001);
    wait_lvl(ok, 1'b0, 200);
    chk("conv_off", {10'h000, conv_en || chg_en}, 11'h000);
    repeat (20) @(negedge clock_i);
    sense_i.ov_above_rise = 1'b0;
    sense_i.ov_below_fall = 1'b1;
    repeat (380) @(negedge clock_i);
    chk("ok_held", {10'h000, ok}, 11'h000);
    wait_lvl(ok, 1'b1, 60);
    sense_i.ov_below_fall = 1'b0;
  endtask
  task automatic t_thr;
    chk("nom", nom, 11'(csl_pkg::HOST_LIM_RST * 11 / 10));
    chk("crit", crit, 11'(csl_pkg::HOST_LIM_RST * csl_pkg::L2PCT_RST / 100 * 11 / 10));
    host.wr(csl_pkg::OFS_VIN_SET, 8'h64);
    host.wr(csl_pkg::OFS_HOT_EN, 8'h7f);
    chk("vin_thr", vth, 11'h05b);
  endtask
  task automatic t_peak;
    {sense_i.surge, sense_i.discharge} = 2'b11;
    repeat (6) @(negedge clock_i);
    chk("lvl2", lim, 11'(csl_pkg::HOST_LIM_RST * csl_pkg::L2PCT_RST / 100));
    {sense_i.surge, sense_i.discharge} = 2'b00;
    repeat (12 * TK) @(negedge clock_i);
    chk("lvl1", lim, {3'h0, csl_pkg::HOST_LIM_RST});
    chk("chg_off", {10'h000, chg_en}, 11'h000);
    repeat (32 * TK) @(negedge clock_i);
    chk("chg_on", {10'h000, chg_en}, 11'h001);
  endtask
  task automatic t_hold;
    host.wr(csl_pkg::OFS_LP_A, 8'h00);
    host.wr(csl_pkg::OFS_LP_B, 8'h00);
    host.wr(csl_pkg::OFS_CTRL, 8'h6c);
    sense_i.cmp_high = 1'b1;
    wait_lvl(thr_n, 1'b0, 12);
    chk("lp_hot", {10'h000, thr_oe}, 11'h001);
    sense_i.cmp_high = 1'b0;
    repeat (15 * TK) @(negedge clock_i);
    chk("ext_held", {10'h000, thr_n}, 11'h000);
    sense_i.vin_low = 1'b1;
    repeat (4) @(negedge clock_i);
    sense_i.vin_low = 1'b0;
    host.wr(csl_pkg::OFS_CTRL, 8'h0c);
    chk("vin_held", {10'h000, thr_n}, 11'h000);
    host.wr(csl_pkg::OFS_HOT_STAT, 8'h00);
    wait_lvl(thr_n, 1'b1, 12);
    chk("freed", {10'h000, thr_oe}, 11'h000);
  endtask
  task automatic t_wdog;
    host.wr(csl_pkg::OFS_WDOG, 8'h01);
    host.wr(csl_pkg::OFS_CHG_CUR, 8'h10);
    repeat (4) @(negedge clock_i);
    chk("ack", {10'h000, ack}, 11'h001);
    chk("cur_set", {3'h0, cur}, 11'h010);
    repeat (csl_pkg::WD_S1 * 1000 * TK - 200) @(negedge clock_i);
    chk("cur_kept", {3'h0, cur}, 11'h010);
    n = 0;
    while (cur !== csl_pkg::WD_CUR_CODE && n < 1500) begin
      @(negedge clock_i);
      n++;
    end
    chk("cur_wd", {3'h0, cur}, {3'h0, csl_pkg::WD_CUR_CODE});
  endtask
  initial begin
    repeat (6) @(negedge clock_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge clock_i);
    chk("ok_rst", {10'h000, ok}, 11'h001);
    chk("thr_rst", {10'h000, thr_n}, 11'h001);
    t_thr();
    t_pulse();
    t_stretch();
    t_peak();
    t_hold();
    t_ov();
    t_wdog();
    conclude();
  end
endmodule

// ===== verif/csl_host_model.sv
/* Host model: two-wire master writing registers. Data line has a pull-up. */
`timescale 1ns/1ps
module csl_host_model (
  // Clock and device pull
  input wire logic clock_i,
  input wire logic dev_pull_i,
  // Bus lines and acknowledge record
  output logic scl_o,
  output logic sda_o,
  output logic ack_o
);
  logic pull_r = 1'b0;
  assign sda_o = !(pull_r || dev_pull_i);
  initial scl_o = 1'b1;
  initial ack_o = 1'b1;
  task automatic hold;
    repeat (6) @(negedge clock_i);
  endtask
  task automatic clk_bit(input logic b, output logic v);
    pull_r = !b;
    hold();
    scl_o = 1'b1;
    hold();
    v = sda_o;
    scl_o = 1'b0;
  endtask
  task automatic send(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], a);
    clk_bit(1'b1, a);
    ack_o = ack_o && !a;
  endtask
  // Start, address, offset, data, stop
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    pull_r = 1'b1;
    hold();
    scl_o = 1'b0;
    send({csl_pkg::DEV_ADDR, 1'b0});
    send(ofs);
    send(d);
    pull_r = 1'b1;
    hold();
    scl_o = 1'b1;
    hold();
    pull_r = 1'b0;
    hold();
  endtask
endmodule

// ===== verif/csl_monitor.sv
/* Checker for csl_top ports. Assumes bind into csl_top. */
`timescale 1ns/1ps
module csl_monitor (
  // Watched ports
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire csl_pkg::csl_sense_type sense_i,
  input wire logic charge_enable_o,
  input wire logic converter_enable_o,
  input wire logic charger_ok_o,
  input wire logic throttle_output_n_o,
  input wire logic throttle_oe_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  logic [11:0] ov_cnt_r;
  // Raw overvoltage run length
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) ov_cnt_r <= 12'h000;
    else if (!sense_i.ov_above_rise) ov_cnt_r <= 12'h000;
    else if (ov_cnt_r != 12'hfff) ov_cnt_r <= ov_cnt_r + 12'h001;
  end
  sequence ov_steady; sense_i.ov_above_rise [*8]; endsequence
  sequence ov_clear; !sense_i.ov_above_rise [*8]; endsequence
  ok_mirror_a: assert property (converter_enable_o == charger_ok_o)
    else $error("converter enable differs from charger ok");
  thr_pin_a: assert property (throttle_oe_o == !throttle_output_n_o)
    else $error("throttle enable not inverse of level");
  sda_od_a: assert property (sda_oe_o |-> !sda_o)
    else $error("data line driven high");
  ok_hold_a: assert property (ov_clear ##1 charger_ok_o |=> charger_ok_o)
    else $error("charger ok dropped without overvoltage");
  off_hold_a: assert property (ov_steady ##1 !charger_ok_o |=> !charger_ok_o)
    else $error("charger ok released during overvoltage");
  chg_off_a: assert property (!charger_ok_o |-> !charge_enable_o)
    else $error("charging on during overvoltage");
  ov_time_a: assert property (ov_cnt_r > 12'hfaa |-> !charger_ok_o)
    else $error("overvoltage not acted on in time");
  thr_min_a: assert property ($fell(throttle_output_n_o) |=> !throttle_output_n_o [*8])
    else $error("throttle pulse too short");
endmodule
bind csl_top csl_monitor mon (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .sense_i(sense_i), .charge_enable_o(charge_enable_o),
  .converter_enable_o(converter_enable_o), .charger_ok_o(charger_ok_o),
  .throttle_output_n_o(throttle_output_n_o), .throttle_oe_o(throttle_oe_o));
